//--- pkg/slcd_regs.vh
/*
  register indices, field positions, reset values and divider figures of the
  segment display controller. assumes inclusion by bare name from the rtl files.
*/
// Summary of operation
// RULE1 - lcd clock is source clock over 32..256
// RULE2 - reset clears the control register fully
// RULE3 - scanning continues in sleep/stop on sub clock
// RULE4 - duty field picks commons; spare commons become segments
// RULE5 - panel driven only while display enabled
// RULE6 - software must keep bias divider enabled
// RULE7 - disable bit stops the sub oscillator
// RULE8 - frame rate is lcd clock over commons
// RULE9 - source field picks sub or main variants
// RULE10 - hardware fetches display memory by itself
// RULE11 - memory bit one lights the intersection
// RULE12 - software selects ram page four first
// RULE13 - after reset the source is sub clock
// RULE14 - bias valid only with sub clock running
// RULE15 - software waits for oscillator before enabling
// RULE16 - duty field sits at control bits 3:2
// RULE17 - commons scanned in order, one lcd period
// RULE18 - select bit zero segment, one port
`ifndef SLCD_REGS_VH
`define SLCD_REGS_VH

// register indices; byte address is four times the index
`define SLCD_IDX_SEL_A 12'h0ac
`define SLCD_IDX_SEL_B 12'h0ad
`define SLCD_IDX_SEL_C 12'h0ae
`define SLCD_IDX_CTRL 12'h0b2
`define SLCD_IDX_STATUS 12'h0b3
`define SLCD_IDX_WATCH 12'h0ea
`define SLCD_IDX_MEM_FIRST 12'h460
`define SLCD_IDX_MEM_LAST 12'h482
`define SLCD_MEM_DEPTH 35

// display control fields
`define SLCD_CTRL_OSC_OFF 7
`define SLCD_CTRL_BIAS_ON 6
`define SLCD_CTRL_DISP_ON 5
`define SLCD_CTRL_DUTY_HI 3
`define SLCD_CTRL_DUTY_LO 2
`define SLCD_CTRL_DIV_HI 1
`define SLCD_CTRL_DIV_LO 0
`define SLCD_CTRL_MASK 8'hef
`define SLCD_CTRL_RESET 8'h00

// watch timer mode: bits 7,6 and 3:0 implemented, 1:0 pick the clock source
`define SLCD_WATCH_MASK 8'hcf
`define SLCD_WATCH_RESET 8'h00
`define SLCD_SELC_MASK 8'h0f
`define SLCD_SEL_RESET 8'h00

// duty codes
`define SLCD_DUTY_QUARTER 2'h0
`define SLCD_DUTY_THIRD 2'h1
`define SLCD_DUTY_HALF 2'h2
`define SLCD_DUTY_STATIC 2'h3

// clock source codes
`define SLCD_SRC_SUB 2'h0
`define SLCD_SRC_MAIN_DIV128 2'h1
`define SLCD_SRC_MAIN 2'h2
`define SLCD_SRC_MAIN_DIV2 2'h3

// divider figures
`define SLCD_PRESCALE_MAIN 128
`define SLCD_DIV_MIN 32

`endif

//--- rtl/slcd_clkgen.v
/*
  lcd clock generator: picks the source clock and divides it down to one
  tick per lcd clock period. assumes sub and main clock pins are slow levels
  sampled by clk; each is synchronised here before edge detection.
*/
`timescale 1ns/1ps
`default_nettype none
`include "slcd_regs.vh"

module slcd_clkgen (
  // system
  input wire clk,
  input wire srst,
  // oscillator pins
  input wire sub_clock,
  input wire main_clock,
  // configuration
  input wire osc_off,
  input wire [1:0] src_sel,
  input wire [1:0] div_sel,
  input wire run,
  // result
  output reg lcd_tick
);

  reg sub_s1, sub_s2, sub_s3;
  reg main_s1, main_s2, main_s3;
  reg [6:0] prescale;
  reg main_half;
  reg [7:0] divcnt;
  reg src_tick;
  wire sub_rise;
  wire main_rise;
  wire [7:0] div_last;

  // 32 << code, minus one
  function [7:0] div_terminal;
    input [1:0] code;
    begin
      div_terminal = (8'd`SLCD_DIV_MIN << code) - 8'd1; // RULE1
    end
  endfunction

  // a stopped oscillator yields no edges at all
  assign sub_rise = sub_s2 & ~sub_s3 & ~osc_off; // RULE7
  assign main_rise = main_s2 & ~main_s3;
  assign div_last = div_terminal(div_sel);

  always @(posedge clk) begin
    if (srst) begin
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
      main_s1 <= 1'b0;
      main_s2 <= 1'b0;
      main_s3 <= 1'b0;
      prescale <= 7'h00;
      main_half <= 1'b0;
    end else begin
      sub_s1 <= sub_clock;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
      main_s1 <= main_clock;
      main_s2 <= main_s1;
      main_s3 <= main_s2;
      if (main_rise) begin
        prescale <= prescale + 7'h01;
        main_half <= ~main_half;
      end
    end
  end

  always @* begin
    case (src_sel) // RULE9
      `SLCD_SRC_SUB: src_tick = sub_rise;
      `SLCD_SRC_MAIN_DIV128: src_tick = main_rise & (prescale == 7'h7f);
      `SLCD_SRC_MAIN: src_tick = main_rise;
      `SLCD_SRC_MAIN_DIV2: src_tick = main_rise & main_half;
      default: src_tick = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      divcnt <= 8'h00;
      lcd_tick <= 1'b0;
    end else begin
      lcd_tick <= 1'b0;
      if (run && src_tick) begin // RULE3
        if (divcnt >= div_last) begin
          divcnt <= 8'h00;
          lcd_tick <= 1'b1;
        end else begin
          divcnt <= divcnt + 8'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- rtl/slcd_top.v
/*
  segment lcd controller top: ahb-lite register slave, display memory and the
  common/segment scanner. assumes a single ahb-lite master, word accesses only,
  and an external analog stage that turns the digital drive levels into bias
  voltages for the panel.
*/
`timescale 1ns/1ps
`default_nettype none
`include "slcd_regs.vh"

module slcd_top (
  // system
  input wire clk,
  input wire srst,
  // ahb-lite slave
  input wire hsel,
  input wire [15:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // oscillators and power modes
  input wire sub_clock,
  input wire main_clock,
  input wire sleep_mode,
  input wire stop_mode,
  input wire sys_clk_is_sub,
  // panel and pin muxing
  output reg [3:0] com_drive,
  output reg [19:0] seg_drive,
  output reg [19:0] seg_is_port,
  output reg [3:0] com_is_seg,
  output reg frame_tick,
  // analog and oscillator control
  output reg sub_osc_disable,
  output reg bias_divider_on,
  output reg bias_valid
);

  localparam ST_IDLE = 3'b001;
  localparam ST_SCAN = 3'b010;
  localparam ST_BLANK = 3'b100;

  reg [7:0] display_control_reg;
  reg [7:0] watch_timer_mode_reg;
  reg [7:0] segment_port_select_a;
  reg [7:0] segment_port_select_b;
  reg [7:0] segment_port_select_c;
  reg [3:0] disp_mem [0:`SLCD_MEM_DEPTH-1];
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] com_idx;
  reg wr_pend;
  reg [11:0] wr_idx;
  reg [31:0] next_rdata;
  reg [3:0] next_com;
  reg [19:0] next_seg;
  reg [3:0] next_com_seg;
  integer i;

  wire [1:0] duty_select;
  wire [1:0] frame_divider_select;
  wire [1:0] watch_clock_source;
  wire display_on;
  wire lcd_tick;
  wire run;
  wire addr_phase;
  wire [11:0] a_idx;
  wire [1:0] last_com;
  wire [19:0] port_sel;
  wire [11:0] rd_off;
  wire [11:0] wr_off;
  wire [5:0] rd_slot;
  wire [5:0] wr_slot;

  // index of the last active common for a duty code
  function [1:0] last_common;
    input [1:0] duty;
    begin
      case (duty)
        `SLCD_DUTY_QUARTER: last_common = 2'h3;
        `SLCD_DUTY_THIRD: last_common = 2'h2;
        `SLCD_DUTY_HALF: last_common = 2'h1;
        default: last_common = 2'h0;
      endcase
    end
  endfunction

  // word index is inside the display memory window
  function in_mem;
    input [11:0] idx;
    begin
      in_mem = (idx >= `SLCD_IDX_MEM_FIRST) && (idx <= `SLCD_IDX_MEM_LAST);
    end
  endfunction

  // memory slot shown by a spare common pin; the highest pin takes the lowest slot
  function [5:0] spare_slot;
    input [1:0] pin;
    begin
      case (pin)
        2'h3: spare_slot = 6'd32;
        2'h2: spare_slot = 6'd33;
        2'h1: spare_slot = 6'd34;
        default: spare_slot = 6'd0;
      endcase
    end
  endfunction

  assign duty_select = display_control_reg[`SLCD_CTRL_DUTY_HI:`SLCD_CTRL_DUTY_LO]; // RULE16
  assign frame_divider_select = display_control_reg[`SLCD_CTRL_DIV_HI:`SLCD_CTRL_DIV_LO];
  assign display_on = display_control_reg[`SLCD_CTRL_DISP_ON];
  assign watch_clock_source = watch_timer_mode_reg[1:0];
  // in sleep or stop the scan survives only when the sub clock runs the system
  assign run = ~(sleep_mode | stop_mode) | sys_clk_is_sub; // RULE3
  assign last_com = last_common(duty_select); // RULE4
  // pins in order: select a holds 7..0, b 15..8, c 19..16
  assign port_sel = {segment_port_select_c[3:0], segment_port_select_b, segment_port_select_a};

  // bus: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & hready & htrans[1];
  assign a_idx = haddr[13:2];
  // window offsets are cut to the slot width on purpose; in_mem guards the range
  assign rd_off = a_idx - `SLCD_IDX_MEM_FIRST;
  assign wr_off = wr_idx - `SLCD_IDX_MEM_FIRST;
  assign rd_slot = rd_off[5:0];
  assign wr_slot = wr_off[5:0];

  slcd_clkgen u_clkgen (
    .clk(clk),
    .srst(srst),
    .sub_clock(sub_clock),
    .main_clock(main_clock),
    .osc_off(display_control_reg[`SLCD_CTRL_OSC_OFF]),
    .src_sel(watch_clock_source),
    .div_sel(frame_divider_select),
    .run(run),
    .lcd_tick(lcd_tick)
  );

  // read data is fetched in the address phase so it stands from a flop
  always @* begin
    next_rdata = 32'h00000000;
    if (in_mem(a_idx)) begin
      // a display nibble reads back in the low bits
      next_rdata = {28'h0000000, disp_mem[rd_slot]};
    end else begin
      case (a_idx)
        `SLCD_IDX_SEL_A: next_rdata = {24'h000000, segment_port_select_a};
        `SLCD_IDX_SEL_B: next_rdata = {24'h000000, segment_port_select_b};
        `SLCD_IDX_SEL_C: next_rdata = {24'h000000, segment_port_select_c};
        `SLCD_IDX_CTRL: next_rdata = {24'h000000, display_control_reg};
        // status: scan state in 4:2, active common in 1:0
        `SLCD_IDX_STATUS: next_rdata = {27'h0, state, com_idx};
        `SLCD_IDX_WATCH: next_rdata = {24'h000000, watch_timer_mode_reg};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      wr_idx <= 12'h000;
    end else begin
      wr_pend <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_idx <= a_idx;
      end
    end
  end

  // read data stands from its address edge until the next read is taken
  always @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // register writes land in the data phase
  always @(posedge clk) begin
    if (srst) begin
      display_control_reg <= `SLCD_CTRL_RESET; // RULE2
      watch_timer_mode_reg <= `SLCD_WATCH_RESET; // RULE13
      segment_port_select_a <= `SLCD_SEL_RESET; // RULE18
      segment_port_select_b <= `SLCD_SEL_RESET;
      segment_port_select_c <= `SLCD_SEL_RESET;
    end else if (wr_pend) begin
      // unimplemented and reserved bits are masked so they read back as 0
      case (wr_idx)
        `SLCD_IDX_SEL_A: segment_port_select_a <= hwdata[7:0];
        `SLCD_IDX_SEL_B: segment_port_select_b <= hwdata[7:0];
        `SLCD_IDX_SEL_C: segment_port_select_c <= hwdata[7:0] & `SLCD_SELC_MASK;
        `SLCD_IDX_CTRL: display_control_reg <= hwdata[7:0] & `SLCD_CTRL_MASK;
        `SLCD_IDX_WATCH: watch_timer_mode_reg <= hwdata[7:0] & `SLCD_WATCH_MASK;
        default: display_control_reg <= display_control_reg;
      endcase
    end
  end

  // display memory keeps its contents over reset; only bus writes change it
  always @(posedge clk) begin
    if (wr_pend && in_mem(wr_idx)) begin
      disp_mem[wr_slot] <= hwdata[3:0];
    end
  end

  // scan sequencer
  always @* begin
    case (state)
      ST_IDLE: next_state = display_on ? ST_SCAN : ST_IDLE;
      ST_SCAN: next_state = display_on ? ST_SCAN : ST_BLANK; // RULE5
      // blank is a one-cycle stop on the way back to idle
      ST_BLANK: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state <= ST_IDLE;
      com_idx <= 2'h0;
      frame_tick <= 1'b0;
    end else begin
      state <= next_state;
      frame_tick <= 1'b0;
      if (state != ST_SCAN) begin
        com_idx <= 2'h0;
      end else if (lcd_tick) begin // RULE17
        if (com_idx >= last_com) begin
          com_idx <= 2'h0;
          // no frame end is reported while the display is being switched off
          frame_tick <= display_on; // RULE8
        end else begin
          com_idx <= com_idx + 2'h1;
        end
      end
    end
  end

  // waveform data straight from display memory, no software copy needed
  always @* begin
    next_com = 4'h0;
    next_seg = 20'h00000;
    next_com_seg = 4'h0;
    for (i = 1; i < 4; i = i + 1) begin
      if (i > last_com) begin
        next_com_seg[i] = 1'b1; // RULE4
      end
    end
    if (state == ST_SCAN) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (next_com_seg[i]) begin
          // spare common pins carry segments 32..34 from the top down
          next_com[i] = disp_mem[spare_slot(i[1:0])][com_idx]; // RULE10
        end else begin
          next_com[i] = (com_idx == i[1:0]);
        end
      end
      for (i = 0; i < 20; i = i + 1) begin
        // a set bit lights the segment on the active common
        next_seg[i] = disp_mem[i][com_idx] & ~port_sel[i]; // RULE11
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      com_drive <= 4'h0;
      seg_drive <= 20'h00000;
      seg_is_port <= 20'h00000;
      com_is_seg <= 4'h0;
    end else begin
      com_drive <= next_com;
      seg_drive <= next_seg;
      seg_is_port <= port_sel; // RULE18
      com_is_seg <= next_com_seg;
    end
  end

  // oscillator and bias controls follow the control register by one cycle
  always @(posedge clk) begin
    if (srst) begin
      sub_osc_disable <= 1'b0;
      bias_divider_on <= 1'b0;
      bias_valid <= 1'b0;
    end else begin
      sub_osc_disable <= display_control_reg[`SLCD_CTRL_OSC_OFF]; // RULE7
      bias_divider_on <= display_control_reg[`SLCD_CTRL_BIAS_ON];
      // the bias ladder is clocked by the sub oscillator
      bias_valid <= display_control_reg[`SLCD_CTRL_BIAS_ON] &
                    ~display_control_reg[`SLCD_CTRL_OSC_OFF]; // RULE14
    end
  end

endmodule

`default_nettype wire

//--- bench/slcd_monitor.sv
/* port assertions for slcd_top: scan order and hold, spare commons,
   port masking, frame pulse, bias status. assumes binding to slcd_top. */
`timescale 1ns/1ps
`default_nettype none
module slcd_monitor (
  // system
  input wire logic clk,
  input wire logic srst,
  // panel side
  input wire logic [3:0] com_drive,
  input wire logic [3:0] com_is_seg,
  input wire logic [19:0] seg_drive,
  input wire logic [19:0] seg_is_port,
  input wire logic frame_tick,
  // analog control
  input wire logic sub_osc_disable,
  input wire logic bias_divider_on,
  input wire logic bias_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [3:0] act;
  logic [3:0] act_q;
  logic [11:0] hold;
  assign act = com_drive & ~com_is_seg;
  // saturates so that a stopped scan cannot wrap the count
  always @(posedge clk) begin
    if (srst) begin
      act_q <= 4'h0;
      hold <= 12'h000;
    end else begin
      act_q <= act;
      if (act != act_q)
        hold <= 12'h000;
      else if (hold != 12'hfff)
        hold <= hold + 12'h001;
    end
  end
  AST_ONEHOT: assert property ($onehot0(act))
    else $error("more than one common active");
  AST_ORDER: assert property ((act != act_q && act != 4'h0 && act_q != 4'h0) |->
    (act == {act_q[2:0], 1'b0} || act == 4'h1)) else $error("commons out of order");
  AST_HOLD: assert property ((act != act_q && act != 4'h0 && act_q != 4'h0) |->
    hold >= 12'd60) else $error("common period too short");
  AST_SPARE: assert property (com_is_seg inside {4'h0, 4'h8, 4'hc, 4'he})
    else $error("bad spare common set");
  AST_PORT: assert property ((seg_drive & seg_is_port) == 20'h0)
    else $error("port pin driven as segment");
  AST_OFF: assert property (act == 4'h0 |->
    (seg_drive == 20'h0 && (com_drive & com_is_seg) == 4'h0)) else $error("segments without common");
  AST_FRAME: assert property (frame_tick |-> ##[0:2] act == 4'h1)
    else $error("frame end without wrap to first common");
  AST_PULSE: assert property (frame_tick |=> !frame_tick)
    else $error("frame pulse too long");
  AST_BIAS: assert property (bias_valid == (bias_divider_on && !sub_osc_disable))
    else $error("bias valid wrong");
endmodule
bind slcd_top slcd_monitor u_slcd_monitor (.clk(clk), .srst(srst), .com_drive(com_drive),
  .com_is_seg(com_is_seg), .seg_drive(seg_drive), .seg_is_port(seg_is_port),
  .frame_tick(frame_tick), .sub_osc_disable(sub_osc_disable),
  .bias_divider_on(bias_divider_on), .bias_valid(bias_valid));
`default_nettype wire

//--- bench/slcd_panel.sv
/* passive segment panel: keeps, per common, the last segment and spare
   common levels seen while that common was active. assumes clk sampling. */
`timescale 1ns/1ps
`default_nettype none
module slcd_panel (
  // system
  input wire logic clk,
  // drive pins
  input wire logic [3:0] com_drive,
  input wire logic [3:0] com_is_seg,
  input wire logic [19:0] seg_drive,
  // what the glass shows
  output var logic [3:0][23:0] pat
);
  // a one on a segment while its common is active lights the spot
  always @(posedge clk) begin
    for (int k = 0; k < 4; k++)
      if (com_drive[k] && !com_is_seg[k])
        pat[k] <= {com_drive & com_is_seg, seg_drive};
  end
endmodule
`default_nettype wire

//--- bench/slcd_top_tb.sv
/* self-checking bench for slcd_top: ahb-lite master, random display data,
   frame timing per duty and source. assumes slcd_regs.vh on include path. */
`timescale 1ns/1ps
`default_nettype none
`include "slcd_regs.vh"
module slcd_top_tb;
  logic clk = 0, srst = 1, hsel = 0, hwrite = 0, sub_clock = 0, main_clock = 0;
  logic sleep_mode = 0, stop_mode = 0, sys_clk_is_sub = 0;
  logic [15:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, seed = 32'h4330, rd;
  logic [7:0] tk = 0;
  logic [3:0] mem [35];
  logic [31:0] wv [5];
  logic [11:0] ridx [5] = '{`SLCD_IDX_SEL_A, `SLCD_IDX_SEL_B, `SLCD_IDX_SEL_C, `SLCD_IDX_CTRL,
    `SLCD_IDX_WATCH};
  logic [7:0] rmsk [5] = '{8'hff, 8'hff, 8'h0f, 8'hef, 8'hcf};
  logic [3:0] cs_exp = 0;
  logic [19:0] port_exp = 0;
  wire hreadyout, hresp, frame_tick, sub_osc_disable, bias_divider_on, bias_valid;
  wire [31:0] hrdata;
  wire [3:0] com_drive, com_is_seg;
  wire [19:0] seg_drive, seg_is_port;
  wire [3:0][23:0] pat;
  int error_cnt = 0, total_checks = 0, cyc = 0, mdiv = 0, c;

  always #2.5 clk = ~clk;
  // oscillator stand-ins: sub period 4 clk, main period 6 clk
  always @(posedge clk) begin
    tk <= tk + 8'h01;
    sub_clock <= sub_osc_disable ? 1'b0 : tk[1];
    mdiv <= (mdiv == 5) ? 0 : mdiv + 1;
    main_clock <= (mdiv >= 3);
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      give_verdict();
    end
  end

  slcd_top u_slcd_top (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sub_clock(sub_clock),
    .main_clock(main_clock), .sleep_mode(sleep_mode), .stop_mode(stop_mode),
    .sys_clk_is_sub(sys_clk_is_sub), .com_drive(com_drive), .seg_drive(seg_drive),
    .seg_is_port(seg_is_port), .com_is_seg(com_is_seg), .frame_tick(frame_tick),
    .sub_osc_disable(sub_osc_disable), .bias_divider_on(bias_divider_on),
    .bias_valid(bias_valid));
  slcd_panel u_slcd_panel (.clk(clk), .com_drive(com_drive), .com_is_seg(com_is_seg),
    .seg_drive(seg_drive), .pat(pat));

  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function logic [23:0] exp_pat(input int k, input logic [3:0] cs);
    logic [23:0] e;
    e = 24'h0;
    for (int n = 0; n < 20; n++)
      e[n] = mem[n][k] & ~port_exp[n];
    for (int j = 1; j < 4; j++)
      if (cs[j])
        e[20 + j] = mem[35 - j][k];
    return e;
  endfunction
  task bus(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {2'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task wait_tick(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (frame_tick !== 1'b1);
  endtask
  task count_ticks(output int n);
    n = 0;
    repeat (600) begin
      @(negedge clk);
      if (frame_tick === 1'b1)
        n++;
    end
  endtask
  task give_verdict;
    $display("errors=%0d checks=%0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ridx[i], 32'h0);
      chk(rd, 32'h0);
      seed = xs(seed);
      wv[i] = seed | 32'h40;
      bus(1'b1, ridx[i], wv[i]);
      bus(1'b0, ridx[i], 32'h0);
      chk(rd, {24'h0, wv[i][7:0] & rmsk[i]});
    end
    bus(1'b1, 12'h0b0, seed);
    bus(1'b0, 12'h0b0, 32'h0);
    chk(rd, 32'h0);
    port_exp = {wv[2][3:0], wv[1][7:0], wv[0][7:0]};
    chk({12'h0, seg_is_port}, {12'h0, port_exp});
    bus(1'b1, `SLCD_IDX_CTRL, 32'h40);
    bus(1'b1, `SLCD_IDX_WATCH, 32'h0);
    for (int n = 0; n < 35; n++) begin
      seed = xs(seed);
      mem[n] = seed[3:0];
      bus(1'b1, `SLCD_IDX_MEM_FIRST + 12'(n), seed);
    end
    chk({30'h0, hreadyout, hresp}, 32'h2);
    // let the sub oscillator run a while before the display goes on
    repeat (16) @(posedge clk);
    // display goes off between settings so the scan restarts cleanly
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, `SLCD_IDX_CTRL, 32'h40);
      bus(1'b1, `SLCD_IDX_CTRL, 32'h60 | (d << 2) | d);
      cs_exp = 4'hf << (4 - d);
      wait_tick(c);
      wait_tick(c);
      chk(c, (32 << d) * 4 * (4 - d));
      chk({28'h0, com_is_seg}, {28'h0, cs_exp});
      for (int k = 0; k < 4 - d; k++)
        chk(pat[k], exp_pat(k, cs_exp));
    end
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `SLCD_IDX_CTRL, 32'h40);
      bus(1'b1, `SLCD_IDX_WATCH, s);
      bus(1'b1, `SLCD_IDX_CTRL, 32'h6c);
      wait_tick(c);
      wait_tick(c);
      chk(c, (s == 0) ? 128 : (s == 1) ? 24576 : (s == 2) ? 192 : 384);
    end
    bus(1'b1, `SLCD_IDX_WATCH, 32'h0);
    sleep_mode <= 1'b1;
    sys_clk_is_sub <= 1'b1;
    count_ticks(c);
    chk(c > 3, 1);
    @(posedge clk);
    sys_clk_is_sub <= 1'b0;
    stop_mode <= 1'b1;
    repeat (10) @(negedge clk);
    count_ticks(c);
    chk(c, 0);
    @(posedge clk);
    stop_mode <= 1'b0;
    sleep_mode <= 1'b0;
    bus(1'b1, `SLCD_IDX_CTRL, 32'hec);
    repeat (10) @(negedge clk);
    chk({sub_osc_disable, bias_divider_on, bias_valid}, 3'b110);
    count_ticks(c);
    chk(c, 0);
    bus(1'b1, `SLCD_IDX_CTRL, 32'h6c);
    count_ticks(c);
    chk(c > 3, 1);
    chk(bias_valid, 1);
    // switch off just after a frame end so the last frame closes cleanly
    wait_tick(c);
    bus(1'b1, `SLCD_IDX_CTRL, 32'h4c);
    repeat (3) @(negedge clk);
    chk({com_drive, seg_drive}, 0);
    give_verdict();
  end
endmodule
`default_nettype wire
